/* sim/serdes_ctrl_regs_assertions.sv */
// Port checker for the serial-link control register bank.
// Assumes i_ce is held high and serial pins are synchronous to i_clk.
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Checker
module serdes_ctrl_regs_chk (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_spi_sclk,
	input wire i_spi_cs_n,
	input wire o_spi_sdo,
	input wire o_spi_sdo_oe_n,
	input wire o_cdr_freeze,
	input wire o_link_logic_rst,
	input wire o_ext_vref_select,
	input wire o_output_current_double,
	input wire [15:0] o_conv0_offset,
	input wire [15:0] o_conv1_offset,
	input wire o_datapath_rst
);
	// Control outputs gathered for stability checks
	wire [4:0] ctl = {o_cdr_freeze, o_link_logic_rst, o_ext_vref_select,
		o_output_current_double, o_datapath_rst};
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// Reset leaves datapath held and all options off
	reset_ctrl_a: assert property ($past(i_sys_rst) |-> ctl == 5'h01)
		else $error("control outputs wrong after reset");
	reset_ofs_a: assert property ($past(i_sys_rst) |-> {o_conv0_offset, o_conv1_offset} == 32'h0)
		else $error("offsets not zero after reset");
	reset_port_a: assert property ($past(i_sys_rst) |-> o_spi_sdo_oe_n && !o_spi_sdo)
		else $error("serial output active after reset");
	// Outputs only move as a result of a frame
	ctrl_quiet_a: assert property (i_spi_cs_n [*4] |-> $stable(ctl))
		else $error("control output moved without a frame");
	ofs_quiet_a: assert property (i_spi_cs_n [*4] |-> $stable({o_conv0_offset, o_conv1_offset}))
		else $error("offset moved without a frame");
	// Read driver only inside a frame, started by a clock rise
	oe_release_a: assert property (i_spi_cs_n && $past(i_spi_cs_n) |-> o_spi_sdo_oe_n)
		else $error("serial output driven while deselected");
	oe_start_a: assert property ($fell(o_spi_sdo_oe_n) |-> !i_spi_cs_n && $past(i_spi_sclk))
		else $error("serial output enabled at wrong time");
	sdo_shift_a: assert property (!o_spi_sdo_oe_n && $past(!o_spi_sdo_oe_n) && $changed(o_spi_sdo)
		|-> !$past(i_spi_sclk))
		else $error("read bit changed outside a clock fall");
endmodule

bind serdes_ctrl_regs serdes_ctrl_regs_chk serdes_ctrl_regs_chk_inst (.i_clk(i_clk),
	.i_sys_rst(i_sys_rst), .i_spi_sclk(i_spi_sclk), .i_spi_cs_n(i_spi_cs_n),
	.o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe_n(o_spi_sdo_oe_n), .o_cdr_freeze(o_cdr_freeze),
	.o_link_logic_rst(o_link_logic_rst), .o_ext_vref_select(o_ext_vref_select),
	.o_output_current_double(o_output_current_double), .o_conv0_offset(o_conv0_offset),
	.o_conv1_offset(o_conv1_offset), .o_datapath_rst(o_datapath_rst));
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the serial-link control register bank.
// Assumes the design sees serial pins synchronously; clock enable stays high.
`timescale 1ns/100ps
`default_nettype none
`include "serdes_ctrl_consts.vh"

// ==========================================================
// Bench top
module testbench;
	logic clk, rst, sclk, cs_n, sdi, rel_try;
	logic [127:0] phase;
	logic [3:0] lock;
	logic [7:0] arrival, b;
	logic [14:0] ctl_addr [0:4];
	integer num_errors = 0;
	integer checks = 0;
	integer j;
	wire sdo, oe_n, freeze, link_rst, vref, cur2, dp_rst;
	wire [15:0] ofs0, ofs1;
	wire [4:0] outs = {freeze, ~dp_rst, cur2, vref, link_rst};

	serdes_ctrl_regs serdes_ctrl_regs_inst (.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
		.i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
		.o_spi_sdo_oe_n(oe_n), .i_cdr_phase_bin(phase), .i_pll_lock(lock),
		.i_ebuf_release_try(rel_try), .i_lane_arrival(arrival), .o_cdr_freeze(freeze),
		.o_link_logic_rst(link_rst), .o_ext_vref_select(vref),
		.o_output_current_double(cur2), .o_conv0_offset(ofs0), .o_conv1_offset(ofs1),
		.o_datapath_rst(dp_rst));

	// 40 MHz clock
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	// Drive 1 ns after the edge so no race with the design
	task tick(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One 24-bit frame; read bits sampled late in the low phase
	task xfer(input logic rw, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
		logic [23:0] f;
		integer k;
		f = {rw, a, d};
		cs_n = 0;
		tick(2);
		for (k = 23; k >= 0; k = k - 1) begin
			sdi = f[k];
			tick(2);
			if (k < 8) q[k] = sdo;
			sclk = 1;
			tick(2);
			sclk = 0;
		end
		tick(3);
		cs_n = 1;
		sdi = ~sdi; // Idle line not left at last value
		tick(2);
	endtask

	task wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b0, a, d, q);
	endtask

	task rdc(input logic [14:0] a, input logic [7:0] e);
		logic [7:0] q;
		xfer(1'b1, a, 8'h00, q);
		chk({8'h00, q}, {8'h00, e});
	endtask

	task pulse;
		rel_try = 1;
		tick(1);
		rel_try = 0;
		tick(1);
	endtask

	task report_and_stop;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog against a hung sequence
	initial begin
		repeat (40000) @(posedge clk);
		num_errors = num_errors + 1;
		report_and_stop;
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1; sclk = 0; cs_n = 1; sdi = 0; rel_try = 0; lock = 4'hF; arrival = 8'hA5;
		for (j = 0; j < 16; j = j + 1) phase[j*8 +: 8] = 8'h13 * j;
		ctl_addr = '{`ADDR_LINK_DIGITAL_RESET, `ADDR_EXTERNAL_REFERENCE_ENABLE,
			`ADDR_DAC_CURRENT_DOUBLER, `ADDR_DATAPATH_ENABLE, `ADDR_CDR_FREEZE};
		tick(20);
		rst = 0;
		tick(1);
		chk({11'h0, outs}, 16'h0000);
		// Each control bit alone; reserved bits not stored
		for (j = 0; j < 5; j = j + 1) begin
			rdc(ctl_addr[j], 8'h00);
			wr(ctl_addr[j], 8'hFF);
			chk({11'h0, outs}, 16'h0001 << j);
			rdc(ctl_addr[j], 8'h01);
			wr(ctl_addr[j], 8'h00);
		end
		// Gray phase of every lane, loop frozen first
		wr(`ADDR_CDR_FREEZE, 8'h01);
		for (j = 0; j < 16; j = j + 1) begin
			wr(`ADDR_LANE_SELECT, j[7:0]);
			b = phase[j*8 +: 8];
			rdc(`ADDR_CDR_PHASE_STATUS, b ^ (b >> 1));
		end
		// Sticky lock-drop flags
		rdc(`ADDR_SERDES_PLL_LOCK_STATUS, 8'hF0);
		lock = 4'hB;
		tick(1);
		lock = 4'hF;
		rdc(`ADDR_SERDES_PLL_LOCK_STATUS, 8'hF4);
		wr(`ADDR_SERDES_PLL_LOCK_STATUS, 8'h00);
		rdc(`ADDR_SERDES_PLL_LOCK_STATUS, 8'hF4);
		wr(`ADDR_SERDES_PLL_LOCK_STATUS, 8'h04);
		rdc(`ADDR_SERDES_PLL_LOCK_STATUS, 8'hF0);
		lock = 4'h6;
		tick(1);
		lock = 4'hD;
		rdc(`ADDR_SERDES_PLL_LOCK_STATUS, 8'hDB);
		wr(`ADDR_SERDES_PLL_LOCK_STATUS, 8'h0F);
		rdc(`ADDR_SERDES_PLL_LOCK_STATUS, 8'hD2);
		lock = 4'hF;
		wr(`ADDR_SERDES_PLL_LOCK_STATUS, 8'h02);
		rdc(`ADDR_SERDES_PLL_LOCK_STATUS, 8'hF0);
		// Offsets held, then released together
		wr(`ADDR_CONV0_OFFSET_LO, 8'h34);
		wr(`ADDR_CONV0_OFFSET_HI, 8'h12);
		chk(ofs0, 16'h1234);
		wr(`ADDR_DAC_OFFSET_UPDATE_HOLD, 8'h01);
		wr(`ADDR_CONV0_OFFSET_LO, 8'hCD);
		wr(`ADDR_CONV1_OFFSET_HI, 8'hAB);
		chk(ofs0, 16'h1234);
		chk(ofs1, 16'h0000);
		wr(`ADDR_DAC_OFFSET_UPDATE_HOLD, 8'h00);
		chk(ofs0, 16'h12CD);
		chk(ofs1, 16'hAB00);
		// Arrival capture only on first release attempt
		pulse;
		arrival = 8'h3C;
		pulse;
		rdc(`ADDR_LANE_ARRIVAL, 8'hA5);
		wr(`ADDR_LINK_DIGITAL_RESET, 8'h01);
		wr(`ADDR_LINK_DIGITAL_RESET, 8'h00);
		pulse;
		rdc(`ADDR_LANE_ARRIVAL, 8'h3C);
		// Unmapped place ignores writes, reads zero
		wr(15'h7FFF, 8'hFF);
		rdc(15'h7FFF, 8'h00);
		// Datapath started last, once configuration is done
		wr(`ADDR_DATAPATH_ENABLE, 8'h01);
		chk({15'h0, dp_rst}, 16'h0000);
		report_and_stop;
	end
endmodule
`default_nettype wire

/* verilog/serdes_ctrl_consts.vh */
// Constants for the serial-link status and datapath control register bank.
// Assumes a 15-bit register address and 8-bit register data on the serial port.
`ifndef SERDES_CTRL_CONSTS_VH
`define SERDES_CTRL_CONSTS_VH

// ==========================================================
// Register addresses
`define ADDR_CDR_FREEZE 15'h0238
`define ADDR_CDR_PHASE_STATUS 15'h0239
`define ADDR_LANE_SELECT 15'h0237
`define ADDR_LANE_ARRIVAL 15'h0240
`define ADDR_SERDES_PLL_LOCK_STATUS 15'h0250
`define ADDR_LINK_DIGITAL_RESET 15'h0253
`define ADDR_EXTERNAL_REFERENCE_ENABLE 15'h02B0
`define ADDR_DAC_CURRENT_DOUBLER 15'h02B1
`define ADDR_CONV0_OFFSET_LO 15'h02C8
`define ADDR_CONV0_OFFSET_HI 15'h02C9
`define ADDR_CONV1_OFFSET_LO 15'h02CA
`define ADDR_CONV1_OFFSET_HI 15'h02CB
`define ADDR_DAC_OFFSET_UPDATE_HOLD 15'h02CF
`define ADDR_DATAPATH_ENABLE 15'h02E0

// ==========================================================
// Field positions
`define LOCK_NOW_MSB 7
`define LOCK_NOW_LSB 4
`define LOCK_DROP_MSB 3
`define LOCK_DROP_LSB 0
`define CTRL_BIT 0

// ==========================================================
// Reset values
`define RST_CTRL_BYTE 8'h00
`define RST_LANE_SELECT 4'h0
`define RST_OFFSET 16'h0000
`define RD_UNMAPPED 8'h00

// ==========================================================
// Serial frame timing, in sampled clock edges, and PLL and lane counts
`define FRAME_BITS 5'h18
`define HEADER_BITS 5'h10
`define NUM_PLL 4
`define NUM_LANES 16

`endif

/* verilog/serdes_ctrl_regs.v */
// Serial-link status, reference, offset and datapath control registers.
// Assumes serial port pins are already synchronous to i_clk and that
// SCLK is slower than a quarter of i_clk so every edge is seen.
`timescale 1ns/100ps
`default_nettype none
`include "serdes_ctrl_consts.vh"

// Functional notes
// - Phase status returns recovery phase of lane picked by lane_select.
// - Phase value is presented in gray code, not binary.
// - Bits 7-4 show live lock of the four PLL macros.
// - Flag bit n sets on any cycle PLL n lock is low.
// - Flags stay set after relock; only writing 1 clears them.
// - link_logic_hold keeps link digital logic reset, lanes untouched.
// - Lane arrival values captured only on first buffer release attempt.
// - ext_vref_select switches converter to external reference.
// - output_current_double doubles output current; resets to normal.
// - While offset_update_hold is 1, converter offsets stay unchanged.
// - On hold falling, both pending offsets apply in the same cycle.
// - datapath_run enables datapath; clear holds it in reset; resets 0.
// - cdr_freeze stops recovery loop tracking and holds its phase.
module serdes_ctrl_regs (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_ce,
	input wire i_spi_sclk,
	input wire i_spi_cs_n,
	input wire i_spi_sdi,
	output wire o_spi_sdo,
	output wire o_spi_sdo_oe_n,
	input wire [127:0] i_cdr_phase_bin,
	input wire [3:0] i_pll_lock,
	input wire i_ebuf_release_try,
	input wire [7:0] i_lane_arrival,
	output wire o_cdr_freeze,
	output wire o_link_logic_rst,
	output wire o_ext_vref_select,
	output wire o_output_current_double,
	output wire [15:0] o_conv0_offset,
	output wire [15:0] o_conv1_offset,
	output wire o_datapath_rst
);

	// ==========================================================
	// Serial port frame engine
	localparam ST_IDLE = 2'b00;
	localparam ST_SHIFT = 2'b01;
	localparam ST_DONE = 2'b10;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg sclk_prev_ff;
	reg [4:0] bit_cnt_ff;
	reg [22:0] shift_in_ff;
	reg rd_frame_ff;
	reg [7:0] shift_out_ff;
	reg sdo_oe_n_ff;
	reg wr_stb_ff;
	reg [14:0] wr_addr_ff;
	reg [7:0] wr_data_ff;
	reg [7:0] rd_data;

	wire sclk_rise;
	wire sclk_fall;
	wire [4:0] bit_cnt_inc;
	wire [14:0] hdr_addr;

	// Pins are synchronous, so the previous sample is enough for edges
	assign sclk_rise = i_spi_sclk & ~sclk_prev_ff;
	assign sclk_fall = ~i_spi_sclk & sclk_prev_ff;
	assign bit_cnt_inc = bit_cnt_ff + 5'h01;
	// After fifteen header bits shifted in, the next one is the last address bit
	assign hdr_addr = {shift_in_ff[13:0], i_spi_sdi};

	// Frame state: a chip-select release always aborts and rearms
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (!i_spi_cs_n) begin
					nxt_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (i_spi_cs_n) begin
					nxt_state = ST_IDLE;
				end else if (sclk_rise && bit_cnt_inc == `FRAME_BITS) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (i_spi_cs_n) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Shifting, read load and write strobe
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_ff <= ST_IDLE;
			sclk_prev_ff <= 1'b0;
			bit_cnt_ff <= 5'h00;
			shift_in_ff <= 23'h000000;
			rd_frame_ff <= 1'b0;
			shift_out_ff <= 8'h00;
			sdo_oe_n_ff <= 1'b1;
			wr_stb_ff <= 1'b0;
			wr_addr_ff <= 15'h0000;
			wr_data_ff <= 8'h00;
		end else if (i_ce) begin
			state_ff <= nxt_state;
			sclk_prev_ff <= i_spi_sclk;
			wr_stb_ff <= 1'b0;
			if (state_ff != ST_SHIFT || i_spi_cs_n) begin
				bit_cnt_ff <= 5'h00;
				if (i_spi_cs_n) begin
					sdo_oe_n_ff <= 1'b1;
				end
			end else if (sclk_rise) begin
				bit_cnt_ff <= bit_cnt_inc;
				shift_in_ff <= {shift_in_ff[21:0], i_spi_sdi};
				if (bit_cnt_ff == 5'h00) begin
					rd_frame_ff <= i_spi_sdi;
				end
				// Read data is fetched once the address is complete
				if (bit_cnt_inc == `HEADER_BITS && rd_frame_ff) begin
					shift_out_ff <= rd_data;
					sdo_oe_n_ff <= 1'b0;
				end
				// Write takes effect only after a full frame
				if (bit_cnt_inc == `FRAME_BITS && !rd_frame_ff) begin
					wr_stb_ff <= 1'b1;
					// Bit 22 holds the R/W flag, so the address sits one place lower
					wr_addr_ff <= shift_in_ff[21:7];
					wr_data_ff <= {shift_in_ff[6:0], i_spi_sdi};
				end
			end else if (sclk_fall && !sdo_oe_n_ff && bit_cnt_ff > `HEADER_BITS) begin
				shift_out_ff <= {shift_out_ff[6:0], 1'b0};
			end
		end
	end

	assign o_spi_sdo = shift_out_ff[7];
	assign o_spi_sdo_oe_n = sdo_oe_n_ff;

	// ==========================================================
	// Control registers
	reg cdr_freeze_ff;
	reg [3:0] lane_sel_ff;
	reg link_hold_ff;
	reg ext_vref_ff;
	reg cur_double_ff;
	reg offset_hold_ff;
	reg dp_run_ff;
	reg [15:0] conv0_pend_ff;
	reg [15:0] conv1_pend_ff;
	reg [15:0] conv0_live_ff;
	reg [15:0] conv1_live_ff;

	wire wr_freeze;
	wire wr_status;

	assign wr_freeze = wr_stb_ff && wr_addr_ff == `ADDR_CDR_FREEZE;
	assign wr_status = wr_stb_ff && wr_addr_ff == `ADDR_SERDES_PLL_LOCK_STATUS;

	// Plain read/write control bits, all zero after reset
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			cdr_freeze_ff <= 1'b0;
			lane_sel_ff <= `RST_LANE_SELECT;
			link_hold_ff <= 1'b0;
			ext_vref_ff <= 1'b0;
			cur_double_ff <= 1'b0;
			offset_hold_ff <= 1'b0;
			dp_run_ff <= 1'b0;
			conv0_pend_ff <= `RST_OFFSET;
			conv1_pend_ff <= `RST_OFFSET;
		end else if (i_ce && wr_stb_ff) begin
			case (wr_addr_ff)
				`ADDR_CDR_FREEZE: cdr_freeze_ff <= wr_data_ff[`CTRL_BIT];
				`ADDR_LANE_SELECT: lane_sel_ff <= wr_data_ff[3:0];
				`ADDR_LINK_DIGITAL_RESET: link_hold_ff <= wr_data_ff[`CTRL_BIT];
				`ADDR_EXTERNAL_REFERENCE_ENABLE: ext_vref_ff <= wr_data_ff[`CTRL_BIT];
				`ADDR_DAC_CURRENT_DOUBLER: cur_double_ff <= wr_data_ff[`CTRL_BIT];
				`ADDR_CONV0_OFFSET_LO: conv0_pend_ff[7:0] <= wr_data_ff;
				`ADDR_CONV0_OFFSET_HI: conv0_pend_ff[15:8] <= wr_data_ff;
				`ADDR_CONV1_OFFSET_LO: conv1_pend_ff[7:0] <= wr_data_ff;
				`ADDR_CONV1_OFFSET_HI: conv1_pend_ff[15:8] <= wr_data_ff;
				`ADDR_DAC_OFFSET_UPDATE_HOLD: offset_hold_ff <= wr_data_ff[`CTRL_BIT];
				`ADDR_DATAPATH_ENABLE: dp_run_ff <= wr_data_ff[`CTRL_BIT];
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Converter offset transfer
	// Both live copies move together, so a release of the hold can never
	// leave the two converters on mismatched offsets for a cycle.
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			conv0_live_ff <= `RST_OFFSET;
			conv1_live_ff <= `RST_OFFSET;
		end else if (i_ce && !offset_hold_ff) begin
			conv0_live_ff <= conv0_pend_ff;
			conv1_live_ff <= conv1_pend_ff;
		end
	end

	// ==========================================================
	// Lock monitoring
	wire [3:0] lock_drop;

	// Flag n watches PLL macro n, which serves lanes 4n to 4n+3
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_PLL; gi = gi + 1) begin : g_lock_drop
			sticky_flag u_flag (
				.i_clk(i_clk),
				.i_sys_rst(i_sys_rst),
				.i_ce(i_ce),
				.i_set(~i_pll_lock[gi]),
				.i_clr(wr_status & wr_data_ff[gi]),
				.o_flag(lock_drop[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Lane arrival capture
	reg arrival_taken_ff;
	reg [7:0] arrival_ff;

	// First attempt only; rearmed while the link logic is held in reset
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			arrival_taken_ff <= 1'b0;
			arrival_ff <= 8'h00;
		end else if (i_ce) begin
			if (link_hold_ff) begin
				arrival_taken_ff <= 1'b0;
			end else if (i_ebuf_release_try && !arrival_taken_ff) begin
				arrival_taken_ff <= 1'b1;
				arrival_ff <= i_lane_arrival;
			end
		end
	end

	// ==========================================================
	// Read data
	wire [7:0] phase_bin;
	wire [7:0] phase_gray;

	assign phase_bin = i_cdr_phase_bin[lane_sel_ff * 8 +: 8];
	assign phase_gray = phase_bin ^ {1'b0, phase_bin[7:1]};

	// Reserved bits read as zero; unmapped addresses read zero
	always @* begin
		rd_data = `RD_UNMAPPED;
		case (hdr_addr)
			`ADDR_CDR_FREEZE: rd_data = {7'h00, cdr_freeze_ff};
			`ADDR_CDR_PHASE_STATUS: rd_data = phase_gray;
			`ADDR_LANE_SELECT: rd_data = {4'h0, lane_sel_ff};
			`ADDR_LANE_ARRIVAL: rd_data = arrival_ff;
			`ADDR_SERDES_PLL_LOCK_STATUS: rd_data = {i_pll_lock, lock_drop};
			`ADDR_LINK_DIGITAL_RESET: rd_data = {7'h00, link_hold_ff};
			`ADDR_EXTERNAL_REFERENCE_ENABLE: rd_data = {7'h00, ext_vref_ff};
			`ADDR_DAC_CURRENT_DOUBLER: rd_data = {7'h00, cur_double_ff};
			`ADDR_CONV0_OFFSET_LO: rd_data = conv0_pend_ff[7:0];
			`ADDR_CONV0_OFFSET_HI: rd_data = conv0_pend_ff[15:8];
			`ADDR_CONV1_OFFSET_LO: rd_data = conv1_pend_ff[7:0];
			`ADDR_CONV1_OFFSET_HI: rd_data = conv1_pend_ff[15:8];
			`ADDR_DAC_OFFSET_UPDATE_HOLD: rd_data = {7'h00, offset_hold_ff};
			`ADDR_DATAPATH_ENABLE: rd_data = {7'h00, dp_run_ff};
			default: rd_data = `RD_UNMAPPED;
		endcase
	end

	// ==========================================================
	// Control outputs
	assign o_cdr_freeze = cdr_freeze_ff;
	assign o_link_logic_rst = link_hold_ff;
	assign o_ext_vref_select = ext_vref_ff;
	assign o_output_current_double = cur_double_ff;
	assign o_conv0_offset = conv0_live_ff;
	assign o_conv1_offset = conv1_live_ff;
	assign o_datapath_rst = ~dp_run_ff;

endmodule
`default_nettype wire

/* verilog/sticky_flag.v */
// One sticky event flag with write-one-to-clear.
// Assumes set and clear are single-clock-domain, synchronous signals.
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Sticky flag cell
module sticky_flag (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_ce,
	input wire i_set,
	input wire i_clr,
	output wire o_flag
);

	reg flag_ff;
	wire nxt_flag;

	// Set beats clear so a drop in the clear cycle is never lost
	assign nxt_flag = i_set | (flag_ff & ~i_clr);

	// Holds its value while the clock enable is low
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			flag_ff <= 1'b0;
		end else if (i_ce) begin
			flag_ff <= nxt_flag;
		end
	end

	assign o_flag = flag_ff;

endmodule
`default_nettype wire
